// ### swt_map.vh
// Register map and timing constants of the sleep wake-up timer
`ifndef SWT_MAP_VH
`define SWT_MAP_VH

`define SWT_AW               10
`define SWT_ADDR_SETUP_A     10'h316
`define SWT_ADDR_SETUP_B     10'h317
`define SWT_ADDR_RELOAD_LOW  10'h318
`define SWT_ADDR_RELOAD_HIGH 10'h319
`define SWT_ADDR_CTRL        10'h31A
`define SWT_ADDR_OSC_STATUS  10'h31B
`define SWT_ADDR_COUNT_LOW   10'h31C
`define SWT_ADDR_COUNT_HIGH  10'h31D
`define SWT_ADDR_IRQ_STATUS  10'h31E
`define SWT_ADDR_IRQ_MASK    10'h31F
`define SWT_ADDR_IRQ_A_EN    10'h320
`define SWT_ADDR_IRQ_B_EN    10'h321
`define SWT_ADDR_SLEEP_CMD   10'h322

`define SWT_PRESCALE_MSB     2
`define SWT_SRC_LSB          3
`define SWT_SRC_MSB          6
`define SWT_WAKE_ARM_BIT     7
`define SWT_CTRL_FLAG_RST    0
`define SWT_CTRL_CAL_REQ     1
`define SWT_STAT_CAL_DONE    0
`define SWT_STAT_FLAG        1
`define SWT_STAT_SLEEP       2
`define SWT_EV_TIMEOUT       0
`define SWT_EV_CAL_DONE      1
`define SWT_EV_WAKE          2
`define SWT_SRC_RC           4'h1

`define SWT_CAL_TIME_NS      1000000
`define SWT_CLK_PERIOD_NS    40
`define SWT_CAL_CYCLES       (`SWT_CAL_TIME_NS / `SWT_CLK_PERIOD_NS)
`define SWT_CNT_RESET        16'h0000
`define SWT_BYTE_ZERO        8'h00

`endif

// ### swt_sleep_wakeup_timer.v
// Sleep wake-up timer with prescaler, down counter and RC calibration
//
// Design decisions made here: the register addresses and the strobed register port.
`include "swt_map.vh"

// Summary of operation
// - Sixteen-bit prescaler, set by a three-bit code, drives sixteen-bit down counter
// - Setup B bits 6:3 pick tick source
// - Setup A bits 2:0 hold prescaler code
// - Codes divide by 1,4,8,16,128,1024,8192,65536
// - Counter loads reload, decrements per prescaled tick
// - Reaching zero raises timeout interrupt
// - Timeout enabled separately onto two lines
// - Armed timeout wakes device from sleep
// - Calibration takes 1 ms, then done flag
module swt_sleep_wakeup_timer #(
  parameter CAL_CYCLES = `SWT_CAL_CYCLES
) (
  input  wire                i_clk_sys,
  input  wire                i_rst_n,
  input  wire                i_xtal_tick,
  input  wire                i_rc_tick,
  input  wire [`SWT_AW-1:0]  i_addr,
  input  wire [7:0]          i_wdata,
  input  wire                i_wr,
  input  wire                i_rd,
  output reg  [7:0]          o_rdata,
  output reg                 o_irq_a,
  output reg                 o_irq_b,
  output reg                 o_irq,
  output reg                 o_sleep,
  output reg                 o_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0]  wake_timer_setup_a;
  reg  [7:0]  wake_timer_setup_b;
  reg  [7:0]  reload_value_low;
  reg  [7:0]  reload_value_high;
  reg  [1:0]  ctrl;
  reg  [7:0]  irq_line_a_enable;
  reg  [7:0]  irq_line_b_enable;
  reg  [7:0]  irq_status;
  reg  [7:0]  irq_mask;
  reg         rc_calibration_done;
  reg         timeout_flag;
  reg  [15:0] count;
  reg  [15:0] presc;
  reg         running;
  reg  [19:0] cal_cnt;
  reg         cal_busy;
  reg         flag_rst_d;

  // Division factor minus one for a prescaler code
  function [15:0] div_max;
    input [2:0] code;
    begin
      case (code)
        3'h0:    div_max = 16'h0000;
        3'h1:    div_max = 16'h0003;
        3'h2:    div_max = 16'h0007;
        3'h3:    div_max = 16'h000F;
        3'h4:    div_max = 16'h007F;
        3'h5:    div_max = 16'h03FF;
        3'h6:    div_max = 16'h1FFF;
        default: div_max = 16'hFFFF;
      endcase
    end
  endfunction

  function hit;
    input [`SWT_AW-1:0] a;
    input [`SWT_AW-1:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Tick selection and counting
  wire [3:0]  src       = wake_timer_setup_b[`SWT_SRC_MSB:`SWT_SRC_LSB];
  wire        tick      = (src == `SWT_SRC_RC) ? i_rc_tick : i_xtal_tick;
  wire [2:0]  code      = wake_timer_setup_a[`SWT_PRESCALE_MSB:0];
  wire        presc_end = tick && (presc >= div_max(code));
  wire        wr_flag   = i_wr && hit(i_addr, `SWT_ADDR_CTRL);
  wire        wr_low    = i_wr && hit(i_addr, `SWT_ADDR_RELOAD_LOW);
  wire        wr_high   = i_wr && hit(i_addr, `SWT_ADDR_RELOAD_HIGH);
  wire        flag_rst  = ctrl[`SWT_CTRL_FLAG_RST];
  wire        rst_seq   = flag_rst_d && !flag_rst;
  wire        zero_hit  = running && presc_end && (count == 16'h0001);
  wire        cal_start = wr_flag && i_wdata[`SWT_CTRL_CAL_REQ] &&
                          !ctrl[`SWT_CTRL_CAL_REQ];
  wire        cal_end   = cal_busy && (cal_cnt == CAL_CYCLES[19:0] - 20'h1);
  wire        armed     = wake_timer_setup_b[`SWT_WAKE_ARM_BIT];
  wire        rd_status = i_rd && hit(i_addr, `SWT_ADDR_IRQ_STATUS);
  wire        sleep_cmd = i_wr && hit(i_addr, `SWT_ADDR_SLEEP_CMD);
  wire [7:0]  events;

  // Reload value as it stands after this cycle's write
  wire [7:0]  next_low    = wr_low ? i_wdata : reload_value_low;
  wire [7:0]  next_high   = wr_high ? i_wdata : reload_value_high;
  wire [15:0] next_reload = {next_high, next_low};
  wire        reload_nz   = (next_reload != `SWT_CNT_RESET);

  assign events[`SWT_EV_TIMEOUT]  = zero_hit;
  assign events[`SWT_EV_CAL_DONE] = cal_end;
  assign events[`SWT_EV_WAKE]     = zero_hit && armed && o_sleep;
  assign events[7:3]              = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and down counter
  reg  [15:0] next_presc;
  reg  [15:0] next_count;
  reg         next_running;

  always @* begin
    next_presc   = presc;
    next_count   = count;
    next_running = running;
    if (wr_flag || wr_low || wr_high) begin
      next_presc   = 16'h0000;
      next_count   = next_reload;
      next_running = (!timeout_flag || rst_seq) && reload_nz;
    end else if (tick && running) begin
      next_presc = presc_end ? 16'h0000 : presc + 16'h0001;
      if (presc_end) begin
        next_count = count - 16'h0001;
        if (count == 16'h0001) begin
          next_running = 1'b0;
        end
      end
    end else if (!running && !timeout_flag) begin
      next_count   = next_reload;
      next_running = reload_nz;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      presc   <= 16'h0000;
      count   <= `SWT_CNT_RESET;
      running <= 1'b0;
    end else begin
      presc   <= next_presc;
      count   <= next_count;
      running <= next_running;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout flag and calibration
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      timeout_flag <= 1'b0;
      flag_rst_d   <= 1'b0;
    end else begin
      flag_rst_d <= flag_rst;
      if (zero_hit)
        timeout_flag <= 1'b1;
      else if (rst_seq)
        timeout_flag <= 1'b0;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cal_busy            <= 1'b0;
      cal_cnt             <= 20'h00000;
      rc_calibration_done <= 1'b0;
    end else if (cal_start) begin
      cal_busy            <= 1'b1;
      cal_cnt             <= 20'h00000;
      rc_calibration_done <= 1'b0;
    end else if (cal_busy) begin
      cal_cnt <= cal_cnt + 20'h00001;
      if (cal_end) begin
        cal_busy            <= 1'b0;
        rc_calibration_done <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wake_timer_setup_a <= `SWT_BYTE_ZERO;
      wake_timer_setup_b <= `SWT_BYTE_ZERO;
      reload_value_low   <= `SWT_BYTE_ZERO;
      reload_value_high  <= `SWT_BYTE_ZERO;
      ctrl               <= 2'h0;
      irq_line_a_enable  <= `SWT_BYTE_ZERO;
      irq_line_b_enable  <= `SWT_BYTE_ZERO;
      irq_mask           <= `SWT_BYTE_ZERO;
    end else if (i_wr) begin
      if (hit(i_addr, `SWT_ADDR_SETUP_A)) begin
        wake_timer_setup_a <= i_wdata;
      end
      if (hit(i_addr, `SWT_ADDR_SETUP_B)) begin
        wake_timer_setup_b <= i_wdata;
      end
      if (hit(i_addr, `SWT_ADDR_RELOAD_LOW)) begin
        reload_value_low <= i_wdata;
      end
      if (hit(i_addr, `SWT_ADDR_RELOAD_HIGH)) begin
        reload_value_high <= i_wdata;
      end
      if (hit(i_addr, `SWT_ADDR_CTRL)) begin
        ctrl <= i_wdata[1:0];
      end
      if (hit(i_addr, `SWT_ADDR_IRQ_A_EN)) begin
        irq_line_a_enable <= i_wdata;
      end
      if (hit(i_addr, `SWT_ADDR_IRQ_B_EN)) begin
        irq_line_b_enable <= i_wdata;
      end
      if (hit(i_addr, `SWT_ADDR_IRQ_MASK)) begin
        irq_mask <= i_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status bits, an event beats a clearing read
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sticky
      always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          irq_status[gi] <= 1'b0;
        end else if (events[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (rd_status) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state and wake pulse
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_sleep <= 1'b0;
      o_wake  <= 1'b0;
    end else begin
      o_wake <= events[`SWT_EV_WAKE];
      if (events[`SWT_EV_WAKE]) begin
        o_sleep <= 1'b0;
      end else if (sleep_cmd) begin
        o_sleep <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status & irq_mask);
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq_a <= 1'b0;
      o_irq_b <= 1'b0;
    end else begin
      o_irq_a <= timeout_flag && irq_line_a_enable[`SWT_EV_TIMEOUT];
      o_irq_b <= timeout_flag && irq_line_b_enable[`SWT_EV_TIMEOUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  function [7:0] read_word;
    input [`SWT_AW-1:0] a;
    begin
      case (a)
        `SWT_ADDR_SETUP_A:     read_word = wake_timer_setup_a;
        `SWT_ADDR_SETUP_B:     read_word = wake_timer_setup_b;
        `SWT_ADDR_RELOAD_LOW:  read_word = reload_value_low;
        `SWT_ADDR_RELOAD_HIGH: read_word = reload_value_high;
        `SWT_ADDR_CTRL:        read_word = {6'h00, ctrl};
        `SWT_ADDR_OSC_STATUS:  read_word = {5'h00, o_sleep, timeout_flag,
                                            rc_calibration_done};
        `SWT_ADDR_COUNT_LOW:   read_word = count[7:0];
        `SWT_ADDR_COUNT_HIGH:  read_word = count[15:8];
        `SWT_ADDR_IRQ_STATUS:  read_word = irq_status;
        `SWT_ADDR_IRQ_MASK:    read_word = irq_mask;
        `SWT_ADDR_IRQ_A_EN:    read_word = irq_line_a_enable;
        `SWT_ADDR_IRQ_B_EN:    read_word = irq_line_b_enable;
        default:               read_word = `SWT_BYTE_ZERO;
      endcase
    end
  endfunction

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= `SWT_BYTE_ZERO;
    end else if (!i_rd) begin
      o_rdata <= `SWT_BYTE_ZERO;
    end else begin
      o_rdata <= read_word(i_addr);
    end
  end

endmodule // swt_sleep_wakeup_timer

// ### swt_sleep_wakeup_timer_sva.sv
// Port assertions of the sleep wake-up timer
`include "swt_map.vh"
module swt_sva #(
  parameter CAL_CYCLES = 25000
) (
  input wire logic               i_clk_sys,
  input wire logic               i_rst_n,
  input wire logic [`SWT_AW-1:0] i_addr,
  input wire logic [7:0]         i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [7:0]         o_rdata,
  input wire logic               o_irq_a,
  input wire logic               o_irq_b,
  input wire logic               o_irq,
  input wire logic               o_sleep,
  input wire logic               o_wake
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_rd_unmapped; i_rd && i_addr > 10'h322 |=> o_rdata == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
  property p_irq_a_off; i_wr && i_addr == 10'h320 && !i_wdata[0] |-> ##2 !o_irq_a; endproperty
  a_irq_a_off: assert property (p_irq_a_off) else $error("line a not disabled");
  property p_irq_b_off; i_wr && i_addr == 10'h321 && !i_wdata[0] |-> ##2 !o_irq_b; endproperty
  a_irq_b_off: assert property (p_irq_b_off) else $error("line b not disabled");
  property p_mask_off; i_wr && i_addr == 10'h31F && i_wdata == 8'h00 |-> ##2 !o_irq; endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq high");
  property p_sleep_set; i_wr && i_addr == 10'h322 |=> o_sleep; endproperty
  a_sleep_set: assert property (p_sleep_set) else $error("sleep not entered");
  property p_wake_pulse; o_wake |=> !o_wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  property p_wake_sleeping; o_wake |-> $past(o_sleep); endproperty
  a_wake_sleeping: assert property (p_wake_sleeping) else $error("wake while awake");
  property p_sleep_drop; o_wake |-> ##[0:1] !o_sleep; endproperty
  a_sleep_drop: assert property (p_sleep_drop) else $error("sleep kept after wake");
endmodule // swt_sva
bind swt_sleep_wakeup_timer swt_sva #(.CAL_CYCLES(CAL_CYCLES)) swt_sva_i (.*);

// ### swt_sleep_wakeup_timer_bench.sv
// Testbench of the sleep wake-up timer
`include "swt_map.vh"
module sleep_wakeup_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst_n = 0, xt = 0, rc = 0, wr = 0, rd = 0, woke = 0;
  logic [9:0] addr = 10'h000;
  logic [7:0] wd = 8'h00, v;
  wire  [7:0] rdata;
  wire        irq_a, irq_b, irq, slp, wake;
  int         errors = 0, tests_run = 0;
  logic [25:0] rows [5] = '{{10'h316, 8'h05, 8'h05}, {10'h317, 8'h08, 8'h08},
    {10'h31F, 8'h07, 8'h07}, {10'h320, 8'h01, 8'h01}, {10'h3FF, 8'h5A, 8'h00}};
  always #20 clk = ~clk;
  always @(posedge clk) if (wake) woke <= 1'b1;
  swt_sleep_wakeup_timer #(.CAL_CYCLES(20)) swt_sleep_wakeup_timer_i (.i_clk_sys(clk),
    .i_rst_n(rst_n), .i_xtal_tick(xt), .i_rc_tick(rc), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq_a(irq_a), .o_irq_b(irq_b),
    .o_irq(irq), .o_sleep(slp), .o_wake(wake));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr8(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    #1;
  endtask
  task rd8(input logic [9:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 v = rdata;
  endtask
  task tick(input int n, input bit use_rc);
    repeat (n) begin
      @(posedge clk); if (use_rc) rc <= 1'b1; else xt <= 1'b1;
      @(posedge clk); rc <= 1'b0; xt <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
  task final_report;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    chk({3'h0, irq_a, irq_b, irq, slp, wake}, 8'h00);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      wr8(rows[k][25:16], rows[k][15:8]);
      rd8(rows[k][25:16]); chk(v, rows[k][7:0]);
    end
    wr8(10'h316, 8'h01); wr8(10'h317, 8'h00); wr8(10'h318, 8'h05); wr8(10'h319, 8'h00);
    wr8(10'h31A, 8'h01); wr8(10'h31A, 8'h00);
    tick(8, 1); rd8(10'h31C); chk(v, 8'h05);
    tick(8, 0); rd8(10'h31C); chk(v, 8'h03);
    rd8(10'h31D); chk(v, 8'h00);
    tick(12, 0); rd8(10'h31B); chk(v, 8'h02);
    chk({7'h0, irq_a}, 8'h01);
    tick(4, 0); rd8(10'h31B); chk(v, 8'h02);
    rd8(10'h31E); chk(v, 8'h01);
    rd8(10'h31E); chk(v, 8'h00);
    wr8(10'h31A, 8'h01); wr8(10'h31A, 8'h00);
    rd8(10'h31B); chk(v, 8'h00);
    wr8(10'h31A, 8'h00); wr8(10'h31A, 8'h02);
    rd8(10'h31B); chk(v, 8'h00);
    repeat (25) @(posedge clk);
    rd8(10'h31B); chk(v, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd8(10'h31E); chk(v, 8'h02);
    wr8(10'h320, 8'h00); wr8(10'h321, 8'h01); wr8(10'h317, 8'h80);
    wr8(10'h31A, 8'h01); wr8(10'h31A, 8'h00); wr8(10'h322, 8'h00);
    chk({7'h0, slp}, 8'h01);
    tick(24, 0);
    chk({6'h0, woke, slp}, 8'h02);
    chk({6'h0, irq_a, irq_b}, 8'h01);
    wr8(10'h31F, 8'h00); repeat (2) @(posedge clk);
    chk({7'h0, irq}, 8'h00);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    final_report();
  end
endmodule // sleep_wakeup_timer_bench
